// >>> design/bei_defines.svh
// Register offsets, field positions and reset values of the bus interface
`ifndef BEI_DEFINES_SVH
`define BEI_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define BEI_OFF_WIDTH 8'h00
`define BEI_OFF_STATES 8'h04
`define BEI_OFF_WAIT_A 8'h08
`define BEI_OFF_WAIT_B 8'h0C
`define BEI_OFF_BUSCTRL 8'h10
`define BEI_OFF_RDNEG 8'h14
`define BEI_OFF_CSX 8'h18
`define BEI_OFF_STATUS 8'h1C

// ==========================================================================
// Reset values
`define BEI_RST_WIDTH 8'h00
`define BEI_RST_STATES 8'hFF
`define BEI_RST_WAIT 16'h7777
`define BEI_RST_BUSCTRL 1'h0
`define BEI_RST_RDNEG 8'h00
`define BEI_RST_CSX 16'h0000

// ==========================================================================
// Field positions
`define BEI_BIT_PIN_WAIT 0
`define BEI_CSX_LEAD_LSB 8
`define BEI_WAIT_NIBBLE 4
`define BEI_WAIT_AREAS 4

`endif

// >>> design/bei_pkg.sv
// Types shared by the basic external bus interface
package bei_pkg;

  // ========================================================================
  // Internal access request
  typedef struct packed {
    logic [2:0] area;
    logic [23:0] addr;
    logic write;
    logic word;
    logic dma;
    logic [15:0] wdata;
  } bei_req_s;

  // ========================================================================
  // Area settings captured at the start of a cycle
  typedef struct packed {
    logic eight_bit;
    logic three_state;
    logic [2:0] waits;
    logic pin_wait;
    logic early_neg;
    logic lead;
    logic trail;
  } bei_cfg_s;

  // ========================================================================
  // Bus states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_LEAD = 7'h02,
    ST_T1 = 7'h04,
    ST_T2 = 7'h08,
    ST_WAIT = 7'h10,
    ST_T3 = 7'h20,
    ST_TRAIL = 7'h40
  } bei_state_e;

endpackage : bei_pkg

// >>> design/bei_sync.sv
// Three-stage synchroniser with agreement filter for the wait pin
`timescale 1ns/1ps

module bei_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o
);

  // ========================================================================
  // Stages
  logic ff1;
  logic ff2;
  logic ff3;
  logic next_level;

  always_comb begin
    next_level = level_o;
    // Only the agreeing later stages may change the level
    if (ff2 == ff3) begin
      next_level = ff3;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ff1 <= 1'h1;
      ff2 <= 1'h1;
      ff3 <= 1'h1;
      level_o <= 1'h1;
    end else begin
      ff1 <= pin_i;
      ff2 <= ff1;
      ff3 <= ff2;
      level_o <= next_level;
    end
  end

endmodule : bei_sync

// >>> design/bei_lanes.sv
// Data-bus half selection and byte routing
`timescale 1ns/1ps

module bei_lanes (
  input wire logic eight_bit_i,
  input wire logic word_i,
  input wire logic odd_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] bus_i,
  output logic hi_en_o,
  output logic lo_en_o,
  output logic [15:0] bus_o,
  output logic [15:0] rdata_o
);

  // ========================================================================
  // Half enables
  always_comb begin
    hi_en_o = eight_bit_i | word_i | ~odd_i;
    lo_en_o = ~eight_bit_i & (word_i | odd_i);
  end

  // ========================================================================
  // Routing; a byte travels in the low byte on the internal side
  always_comb begin
    if (word_i && !eight_bit_i) begin
      bus_o = wdata_i;
      rdata_o = bus_i;
    end else if (lo_en_o) begin
      bus_o = {8'h00, wdata_i[7:0]};
      rdata_o = {8'h00, bus_i[7:0]};
    end else begin
      bus_o = {wdata_i[7:0], 8'h00};
      rdata_o = {8'h00, bus_i[15:8]};
    end
  end

endmodule : bei_lanes

// >>> design/bei_top.sv
// Basic external bus interface: registers, bus state machine, pins
//
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "bei_defines.svh"

module bei_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic req_valid_i,
  input wire bei_pkg::bei_req_s req_i,
  output logic req_ready_o,
  output logic done_o,
  output logic [15:0] rdata_o,
  output logic [7:0] cs_n_o,
  output logic [23:0] addr_o,
  output logic address_strobe_n_o,
  output logic read_strobe_n_o,
  output logic high_byte_write_strobe_n_o,
  output logic low_byte_write_strobe_n_o,
  output logic dma_acknowledge_n_o,
  output logic [15:0] data_o,
  output logic [1:0] data_oe_o,
  input wire logic [15:0] data_i,
  input wire logic wait_n_i
);

  // ========================================================================
  // Register file
  logic [7:0] width_reg;
  logic [7:0] states_reg;
  logic [15:0] wait_count_reg_a;
  logic [15:0] wait_count_reg_b;
  logic pin_wait_enable;
  logic [7:0] read_negate_control;
  logic [15:0] select_extension_ctrl;
  logic [7:0] next_width;
  logic [7:0] next_states;
  logic [15:0] next_wait_a;
  logic [15:0] next_wait_b;
  logic next_pin_wait;
  logic [7:0] next_rdneg;
  logic [15:0] next_csx;
  logic [31:0] next_dat;
  logic next_ack;
  logic wb_hit;

  function automatic logic [15:0] apply_sel(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) res[7:0] = dat[7:0];
    if (sel[1]) res[15:8] = dat[15:8];
    return res;
  endfunction : apply_sel

  function automatic logic [2:0] wait_of(input logic [2:0] area,
                                         input logic [15:0] reg_a,
                                         input logic [15:0] reg_b);
    logic [15:0] src;
    logic [3:0] nib;
    src = area[2] ? reg_a : reg_b;
    nib = src[area[1:0] * `BEI_WAIT_NIBBLE +: `BEI_WAIT_NIBBLE];
    return nib[2:0];
  endfunction : wait_of

  bei_pkg::bei_state_e state;

  always_comb begin
    wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_ack = wb_hit;
    next_width = width_reg;
    next_states = states_reg;
    next_wait_a = wait_count_reg_a;
    next_wait_b = wait_count_reg_b;
    next_pin_wait = pin_wait_enable;
    next_rdneg = read_negate_control;
    next_csx = select_extension_ctrl;
    next_dat = 32'h00000000;
    if (wb_hit && wb_we_i) begin
      case (wb_adr_i)
        `BEI_OFF_WIDTH: next_width = wb_sel_i[0] ? wb_dat_i[7:0] : width_reg;
        `BEI_OFF_STATES: next_states =
          wb_sel_i[0] ? wb_dat_i[7:0] : states_reg;
        `BEI_OFF_WAIT_A: next_wait_a =
          apply_sel(wait_count_reg_a, wb_dat_i, wb_sel_i);
        `BEI_OFF_WAIT_B: next_wait_b =
          apply_sel(wait_count_reg_b, wb_dat_i, wb_sel_i);
        `BEI_OFF_BUSCTRL: next_pin_wait = wb_sel_i[0] ?
          wb_dat_i[`BEI_BIT_PIN_WAIT] : pin_wait_enable;
        `BEI_OFF_RDNEG: next_rdneg =
          wb_sel_i[0] ? wb_dat_i[7:0] : read_negate_control;
        `BEI_OFF_CSX: next_csx =
          apply_sel(select_extension_ctrl, wb_dat_i, wb_sel_i);
        default: next_csx = select_extension_ctrl;
      endcase
    end
    if (wb_hit && !wb_we_i) begin
      case (wb_adr_i)
        `BEI_OFF_WIDTH: next_dat = {24'h000000, width_reg};
        `BEI_OFF_STATES: next_dat = {24'h000000, states_reg};
        `BEI_OFF_WAIT_A: next_dat = {16'h0000, wait_count_reg_a};
        `BEI_OFF_WAIT_B: next_dat = {16'h0000, wait_count_reg_b};
        `BEI_OFF_BUSCTRL: next_dat = {31'h00000000, pin_wait_enable};
        `BEI_OFF_RDNEG: next_dat = {24'h000000, read_negate_control};
        `BEI_OFF_CSX: next_dat = {16'h0000, select_extension_ctrl};
        `BEI_OFF_STATUS: next_dat = {24'h000000, state, ~req_ready_o};
        default: next_dat = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      width_reg <= `BEI_RST_WIDTH;
      states_reg <= `BEI_RST_STATES;
      wait_count_reg_a <= `BEI_RST_WAIT;
      wait_count_reg_b <= `BEI_RST_WAIT;
      pin_wait_enable <= `BEI_RST_BUSCTRL;
      read_negate_control <= `BEI_RST_RDNEG;
      select_extension_ctrl <= `BEI_RST_CSX;
      wb_dat_o <= 32'h00000000;
      wb_ack_o <= 1'h0;
    end else begin
      width_reg <= next_width;
      states_reg <= next_states;
      wait_count_reg_a <= next_wait_a;
      wait_count_reg_b <= next_wait_b;
      pin_wait_enable <= next_pin_wait;
      read_negate_control <= next_rdneg;
      select_extension_ctrl <= next_csx;
      wb_dat_o <= next_dat;
      wb_ack_o <= next_ack;
    end
  end

  // ========================================================================
  // Bus state machine; each bus state other than ST_IDLE lasts two clocks, phase 1 is the
  // falling half of the state
  logic wait_level_n;
  bei_pkg::bei_req_s cur;
  bei_pkg::bei_cfg_s cfg;
  bei_pkg::bei_cfg_s snap;
  bei_pkg::bei_state_e next_state;
  bei_pkg::bei_req_s next_cur;
  bei_pkg::bei_cfg_s next_cfg;
  logic phase;
  logic next_phase;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic wait_low;
  logic next_wait_low;
  logic next_done;
  logic [15:0] next_rdata;
  logic hi_en;
  logic lo_en;
  logic [15:0] bus_out;
  logic [15:0] bus_rdata;
  logic two_state;
  logic more_wait;

  bei_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(wait_n_i),
    .level_o(wait_level_n)
  );

  bei_lanes u_lanes (
    .eight_bit_i(next_cfg.eight_bit),
    .word_i(next_cur.word),
    .odd_i(next_cur.addr[0]),
    .wdata_i(next_cur.wdata),
    .bus_i(data_i),
    .hi_en_o(hi_en),
    .lo_en_o(lo_en),
    .bus_o(bus_out),
    .rdata_o(bus_rdata)
  );

  always_comb begin
    snap.eight_bit = width_reg[req_i.area];
    snap.three_state = states_reg[req_i.area];
    snap.waits = states_reg[req_i.area] ?
      wait_of(req_i.area, wait_count_reg_a, wait_count_reg_b) : 3'h0;
    snap.pin_wait = pin_wait_enable;
    snap.early_neg = read_negate_control[req_i.area];
    snap.lead = select_extension_ctrl[`BEI_CSX_LEAD_LSB + req_i.area];
    snap.trail = select_extension_ctrl[req_i.area];
  end

  always_comb begin
    two_state = ~cfg.three_state;
    // Pins are evaluated only once the programmed waits are used up
    more_wait = (cnt != 3'h0) | wait_low;
    next_state = state;
    next_phase = phase;
    next_cnt = cnt;
    next_cur = cur;
    next_cfg = cfg;
    next_wait_low = wait_low;
    next_done = 1'h0;
    next_rdata = rdata_o;
    case (state)
      bei_pkg::ST_IDLE: begin
        next_phase = 1'h0;
        if (req_valid_i) begin
          next_cur = req_i;
          next_cfg = snap;
          next_cnt = snap.waits;
          next_state = snap.lead ? bei_pkg::ST_LEAD : bei_pkg::ST_T1;
        end
      end
      bei_pkg::ST_LEAD: begin
        next_phase = ~phase;
        if (phase) next_state = bei_pkg::ST_T1;
      end
      bei_pkg::ST_T1: begin
        next_phase = ~phase;
        if (phase) next_state = bei_pkg::ST_T2;
      end
      bei_pkg::ST_T2, bei_pkg::ST_WAIT: begin
        next_phase = ~phase;
        if (!phase) begin
          // Sixteen-bit two-state cycles ignore the pin entirely
          next_wait_low = cfg.pin_wait & ~wait_level_n & (cnt == 3'h0) &
            ~(two_state & ~cfg.eight_bit);
        end else if (more_wait) begin
          next_state = bei_pkg::ST_WAIT;
          if (cnt != 3'h0) next_cnt = cnt - 3'h1;
        end else if (cfg.three_state) begin
          next_state = bei_pkg::ST_T3;
        end else begin
          next_rdata = cur.write ? rdata_o : bus_rdata;
          next_state = cfg.trail ? bei_pkg::ST_TRAIL : bei_pkg::ST_IDLE;
          next_done = ~cfg.trail;
        end
      end
      bei_pkg::ST_T3: begin
        next_phase = ~phase;
        next_wait_low = 1'h0;
        if (phase) begin
          next_rdata = cur.write ? rdata_o : bus_rdata;
          next_state = cfg.trail ? bei_pkg::ST_TRAIL : bei_pkg::ST_IDLE;
          next_done = ~cfg.trail;
        end
      end
      bei_pkg::ST_TRAIL: begin
        next_phase = ~phase;
        if (phase) begin
          next_state = bei_pkg::ST_IDLE;
          next_done = 1'h1;
        end
      end
      default: begin
        next_state = bei_pkg::ST_IDLE;
        next_phase = 1'h0;
      end
    endcase
  end

  // ========================================================================
  // Pin values from the coming state, so every pin is a flip-flop
  logic n_active;
  logic n_ext;
  logic n_core;
  logic n_last;
  logic n_rd;
  logic n_wr;

  always_comb begin
    n_active = next_state != bei_pkg::ST_IDLE;
    n_ext = (next_state == bei_pkg::ST_LEAD) |
      (next_state == bei_pkg::ST_TRAIL);
    n_core = n_active & ~n_ext & ~((next_state == bei_pkg::ST_T1) &
      ~next_phase);
    n_last = (next_state == bei_pkg::ST_T3) | (~next_cfg.three_state &
      ((next_state == bei_pkg::ST_T2) | (next_state == bei_pkg::ST_WAIT)) &
      (next_cnt == 3'h0) & ~next_wait_low);
    // Early negation trades read hold for faster bus turnaround
    n_rd = n_core & ~next_cur.write &
      ~(n_last & next_phase & next_cfg.early_neg);
    n_wr = n_core & next_cur.write & ~(n_last & next_phase) &
      ~((next_state == bei_pkg::ST_T1) & next_cfg.three_state);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= bei_pkg::ST_IDLE;
      phase <= 1'h0;
      cnt <= 3'h0;
      cur <= '0;
      cfg <= '0;
      wait_low <= 1'h0;
      done_o <= 1'h0;
      rdata_o <= 16'h0000;
      req_ready_o <= 1'h1;
      cs_n_o <= 8'hFF;
      addr_o <= 24'h000000;
      address_strobe_n_o <= 1'h1;
      read_strobe_n_o <= 1'h1;
      high_byte_write_strobe_n_o <= 1'h1;
      low_byte_write_strobe_n_o <= 1'h1;
      dma_acknowledge_n_o <= 1'h1;
      data_o <= 16'h0000;
      data_oe_o <= 2'h0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      cnt <= next_cnt;
      cur <= next_cur;
      cfg <= next_cfg;
      wait_low <= next_wait_low;
      done_o <= next_done;
      rdata_o <= next_rdata;
      req_ready_o <= next_state == bei_pkg::ST_IDLE;
      cs_n_o <= n_active ? ~(8'h01 << next_cur.area) : 8'hFF;
      addr_o <= n_active ? next_cur.addr : addr_o;
      address_strobe_n_o <= ~(n_core | n_ext);
      read_strobe_n_o <= ~n_rd;
      high_byte_write_strobe_n_o <= ~(n_wr & hi_en);
      low_byte_write_strobe_n_o <= ~(n_wr & lo_en);
      // Acknowledge follows the core states only, never the read strobe
      dma_acknowledge_n_o <= ~(n_core & next_cur.dma);
      data_o <= bus_out;
      data_oe_o <= (n_active & next_cur.write) ?
        {hi_en, lo_en} : 2'h0;
    end
  end

  // ========================================================================
  // Checks
  a_rd_not_write: assert property (@(posedge clk_i) disable iff (rst_i)
    !data_oe_o[0] && !data_oe_o[1] |-> high_byte_write_strobe_n_o &&
    low_byte_write_strobe_n_o) else $error("write strobe without data");
  a_eight_bit_lane: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg.eight_bit && state != bei_pkg::ST_IDLE |-> low_byte_write_strobe_n_o
    && !data_oe_o[0]) else $error("low half used in 8-bit space");
  a_ext_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == bei_pkg::ST_LEAD || state == bei_pkg::ST_TRAIL) |->
    read_strobe_n_o && high_byte_write_strobe_n_o && low_byte_write_strobe_n_o
    && !address_strobe_n_o && cs_n_o != 8'hFF)
    else $error("strobe active in extension");
  a_no_wait_16: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg.eight_bit && !cfg.three_state |-> state != bei_pkg::ST_WAIT)
    else $error("wait in 16-bit 2-state");
  a_prog_wait_first: assert property (@(posedge clk_i) disable iff (rst_i)
    state == bei_pkg::ST_WAIT && !phase && cnt != 3'h0 |=> wait_low == 1'h0
    ##1 state == bei_pkg::ST_WAIT)
    else $error("pin wait before program waits");
  a_pin_wait_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    state == bei_pkg::ST_WAIT && phase && wait_low |=>
    state == bei_pkg::ST_WAIT [*2]) else $error("pin wait not honoured");
  a_pin_wait_off: assert property (@(posedge clk_i) disable iff (rst_i)
    state == bei_pkg::ST_T2 && phase && cnt == 3'h0 && !cfg.pin_wait &&
    cfg.three_state |=> state == bei_pkg::ST_T3)
    else $error("wait while pin wait disabled");
  a_reset_values: assert property (@(posedge clk_i)
    $past(rst_i) |-> states_reg == 8'hFF && wait_count_reg_a == 16'h7777 &&
    wait_count_reg_b == 16'h7777 && !pin_wait_enable)
    else $error("bad reset configuration");
  a_early_negate: assert property (@(posedge clk_i) disable iff (rst_i)
    state == bei_pkg::ST_T3 && phase && cfg.early_neg |-> read_strobe_n_o)
    else $error("read strobe not negated early");
  a_dma_acknowledge_steady: assert property (@(posedge clk_i) disable iff (rst_i)
    state == bei_pkg::ST_T3 && phase && cur.dma |-> !dma_acknowledge_n_o)
    else $error("acknowledge moved with read strobe");
  a_lead_first: assert property (@(posedge clk_i) disable iff (rst_i)
    state == bei_pkg::ST_LEAD && phase |=> state == bei_pkg::ST_T1 && !phase)
    else $error("lead state not before state one");

endmodule : bei_top

// >>> verification/bei_mem_model.sv
// Behavioural external 16-bit memory with a wait pin
`timescale 1ns/1ps
module bei_mem_model (
  input wire logic clk_i,
  input wire logic [7:0] cs_n_i,
  input wire logic [23:0] addr_i,
  input wire logic as_n_i,
  input wire logic rd_n_i,
  input wire logic hw_n_i,
  input wire logic lw_n_i,
  input wire logic [15:0] wd_i,
  input wire logic [3:0] stall_i,
  output logic [15:0] rd_o,
  output logic wait_n_o
);
  // ==========
  // Storage and pins
  logic [15:0] mem [256];
  logic [15:0] last = 16'h0000;
  logic rd_n_q = 1'b1;
  logic as_q = 1'b1;
  logic [3:0] cnt = 4'h0;
  wire sel = cs_n_i != 8'hFF;
  wire [7:0] ix = addr_i[8:1];
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'hA55A ^ 16'(i);
  end
  // One cycle of hold after the strobe; then a changing pattern
  assign rd_o = (sel && (!rd_n_i || !rd_n_q)) ? mem[ix] : ~last;
  always @(posedge clk_i) begin
    last <= rd_o;
    rd_n_q <= rd_n_i;
    as_q <= as_n_i;
    if (sel && !hw_n_i) mem[ix][15:8] <= wd_i[15:8];
    if (sel && !lw_n_i) mem[ix][7:0] <= wd_i[7:0];
    if (as_q && !as_n_i) cnt <= stall_i;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
  assign wait_n_o = (cnt == 4'h0);
endmodule : bei_mem_model

// >>> verification/tb_basic_external_bus_if.sv
// Self-checking bench of the basic external bus interface
`timescale 1ns/1ps
module tb_basic_external_bus_if;
  // ==========
  // Signals
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o;
  logic wb_ack_o, req_valid_i = 0, req_ready_o, done_o;
  bei_pkg::bei_req_s req_i = '0;
  logic [15:0] rdata_o, data_o, mrd, bus;
  logic [7:0] cs_n_o;
  logic [23:0] addr_o;
  logic as_n, rd_n, hw_n, lw_n, wait_n;
  logic [1:0] data_oe_o;
  logic [3:0] stall = 0;
  int fails = 0, comparisons = 0, cyc = 0;
  logic [15:0] rf [256];
  logic [15:0] sd = 16'h005B;
  logic [7:0] w8 = 0, st3 = 8'hFF, rdn = 0;
  logic [15:0] wa = 16'h7777, wbr = 16'h7777, csx = 0;
  assign bus = {data_oe_o[1] ? data_o[15:8] : mrd[15:8],
                data_oe_o[0] ? data_o[7:0] : mrd[7:0]};
  initial forever #2.5 clk_i = ~clk_i;
  bei_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .done_o(done_o), .rdata_o(rdata_o),
    .cs_n_o(cs_n_o), .addr_o(addr_o), .address_strobe_n_o(as_n),
    .read_strobe_n_o(rd_n), .high_byte_write_strobe_n_o(hw_n),
    .low_byte_write_strobe_n_o(lw_n), .dma_acknowledge_n_o(),
    .data_o(data_o), .data_oe_o(data_oe_o), .data_i(bus),
    .wait_n_i(wait_n));
  bei_mem_model u_mem (.clk_i(clk_i), .cs_n_i(cs_n_o), .addr_i(addr_o),
    .as_n_i(as_n), .rd_n_i(rd_n), .hw_n_i(hw_n), .lw_n_i(lw_n),
    .wd_i(bus), .stall_i(stall), .rd_o(mrd), .wait_n_o(wait_n));
  // ==========
  // Tasks
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task chk_val(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val
  task chk_cnt(input string nm, input int e, g);
    comparisons++;
    if (g != e) begin
      fails++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_cnt
  task end_of_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d,
          output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask : wb
  task cfg(input logic [2:0] a, input logic e8, t3, input logic [2:0] w,
           input logic en, ld, tr);
    logic [31:0] q;
    w8[a] = e8;
    st3[a] = t3;
    rdn[a] = en;
    csx[a + 8] = ld;
    csx[a] = tr;
    if (a < 4) wbr[a * 4 +: 3] = w;
    else wa[(a - 4) * 4 +: 3] = w;
    wb(1, 8'h00, {24'h0, w8}, q);
    wb(1, 8'h04, {24'h0, st3}, q);
    wb(1, 8'h08, {16'h0, wa}, q);
    wb(1, 8'h0C, {16'h0, wbr}, q);
    wb(1, 8'h14, {24'h0, rdn}, q);
    wb(1, 8'h18, {16'h0, csx}, q);
  endtask : cfg
  // The select length of pin-extended cycles is only checked for being longer and whole
  task acc(input logic [2:0] a, input logic [23:0] ad,
           input logic we, wd, input logic [15:0] d, input logic pn);
    int n, c, csc, rdc, hc, lc, oh, ol, x;
    logic hi, lo;
    logic [15:0] e;
    x = csx[a + 8] + csx[a];
    n = (st3[a] ? 3 + (a < 4 ? wbr[a * 4 +: 3] : wa[(a - 4) * 4 +: 3]) : 2) + x;
    hi = w8[a] | wd | !ad[0];
    lo = !w8[a] & (wd | ad[0]);
    {c, csc, rdc, hc, lc, oh, ol} = 0;
    @(posedge clk_i);
    req_valid_i <= 1;
    req_i <= '{area:a, addr:ad, write:we, word:wd, dma:1'b0, wdata:d};
    do @(posedge clk_i); while (req_ready_o !== 1'b1);
    req_valid_i <= 0;
    do begin
      @(posedge clk_i);
      c++;
      csc += (cs_n_o === ~(8'h01 << a));
      rdc += !rd_n;
      hc += !hw_n;
      lc += !lw_n;
      oh += data_oe_o[1];
      ol += data_oe_o[0];
    end while (done_o !== 1'b1 && c < 400);
    if (pn) chk_val("pin wait", 1, csc > 2 * n && csc % 2 == 0);
    else chk_cnt("select cycles", 2 * n, csc);
    chk_cnt("read strobe", we ? 0 : csc - 2 * x - 1 - rdn[a], rdc);
    x = st3[a] ? csc - 2 * x - 3 : 2;
    chk_cnt("high strobe", (we && hi) ? x : 0, hc);
    chk_cnt("low strobe", (we && lo) ? x : 0, lc);
    chk_cnt("upper drive", (we && hi) ? csc : 0, oh);
    chk_cnt("lower drive", (we && lo) ? csc : 0, ol);
    e = rf[ad[8:1]];
    if (!wd) e = {8'h00, hi ? e[15:8] : e[7:0]};
    if (!we) chk_val("read data", e, wd ? rdata_o : rdata_o[7:0]);
    if (we && hi) rf[ad[8:1]][15:8] = wd ? d[15:8] : d[7:0];
    if (we && lo) rf[ad[8:1]][7:0] = d[7:0];
  endtask : acc
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      end_of_test();
    end
  end
  // ==========
  // Main sequence
  initial begin
    logic [31:0] q;
    logic [23:0] ad;
    logic wd;
    for (int i = 0; i < 256; i++) rf[i] = 16'hA55A ^ 16'(i);
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h04, 0, q);
    chk_val("state count", 32'hFF, q);
    wb(0, 8'h0C, 0, q);
    chk_val("wait low", 32'h7777, q);
    wb(0, 8'h10, 0, q);
    chk_val("pin enable", 0, q);
    wb(1, 8'h14, 32'hFF, q);
    wb(0, 8'h14, 0, q);
    chk_val("negate bits", 32'hFF, q);
    wb(1, 8'h20, 32'hFFFF, q);
    wb(0, 8'h20, 0, q);
    chk_val("unmapped", 0, q);
    wb(1, 8'h14, 0, q);
    acc(3'd5, 24'h10, 0, 1, 0, 0);
    $display("reset test done");
    repeat (40) begin
      sd = lfsr(sd);
      cfg(sd[2:0], sd[3], sd[4], sd[7:5], sd[8], sd[9], sd[10]);
      wd = sd[12] & !sd[3];
      ad = {19'h0, sd[15:11]};
      if (wd) ad[0] = 0;
      sd = lfsr(sd);
      acc(w8[2:0] == w8[2:0] ? ad[23:21] ^ ad[23:21] ^ sd[2:0] : 3'd0,
          ad, sd[15], wd & !w8[sd[2:0]], lfsr(sd), 0);
    end
    $display("random test done");
    // Both areas share the single pin enable
    wb(1, 8'h10, 32'h1, q);
    for (int k = 2; k < 8; k += 4) begin
      cfg(k, 0, 1, 3, 0, 0, 0);
      stall = 15;
      acc(k, 24'h4, 0, 1, 0, 1);
      stall = 2;
      acc(k, 24'h6, 1, 1, 16'h3C5A, 0);
      cfg(k, 0, 0, 0, 1, 1, 1);
      stall = 15;
      acc(k, 24'h6, 0, 1, 0, 0);
    end
    $display("pin wait test done");
    end_of_test();
  end
endmodule : tb_basic_external_bus_if
